// ### include/cmp_skip_pkg.sv
// Purpose: Constants for the complement / compare-skip execution block
// Assumes: 16-bit instruction words, 8-bit data path, 12-bit data address
// Notes: Phases Q1..Q4 are one clock each
package cmp_skip_pkg;
    // ------------------------------------------------------------------
    // Opcode fields
    // ------------------------------------------------------------------
    localparam logic [5:0] COMPLEMENT_OPC = 6'h07;   // 0001 11da
    localparam logic [6:0] COMPARE_EQ_OPC = 7'h31;   // 0110 001a
    localparam int DEST_BIT = 9;
    localparam int ACCESS_BIT = 8;
    localparam logic [7:0] INDEXED_LIMIT = 8'h5F;
    localparam logic [7:0] ACCESS_HIGH_BASE = 8'h60;
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] WORK_RESET = 8'h00;
    localparam logic [1:0] SKIP_RESET = 2'h0;
    // Phase states
    typedef enum logic [3:0]
    {
        PH_Q1 = 4'b0001,
        PH_Q2 = 4'b0010,
        PH_Q3 = 4'b0100,
        PH_Q4 = 4'b1000
    } phase_t;
endpackage : cmp_skip_pkg

// ### verilog/cmp_skip_exec.sv
// Purpose: Executes complement-file and compare-equal-skip instructions
// Assumes: Instruction word and next-word size presented at Q1; memory read data valid in Q3
// Notes: Other instructions do nothing here but are not flagged on noOpCycle
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// RULE1: Complement opcode yields bitwise inverse of addressed file register.
// RULE2: Destination bit 0 writes working register, 1 writes file register.
// RULE3: Access bit 0 maps file address into fixed access bank.
// RULE4: Access bit 1 forms address from bank select register and file field.
// RULE5: Access 0, extended set, file at most 95: indexed literal offset addressing.
// RULE6: Compare-skip compares memory byte with working register by unsigned subtraction.
// RULE7: Equal result discards fetched instruction; one no-operation cycle follows.
// RULE8: Skipped two-word instruction causes two no-operation cycles.
// RULE9: Complement updates N and Z; compare-skip changes no flags or registers.
// RULE10: One word each; complement writes destination in fourth phase; a file destination gets its memWrite pulse in the next Q1.
module cmp_skip_exec
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Instruction fetch
    input wire logic [15:0] instrWord,
    input wire logic nextIsTwoWord,
    // Core context
    input wire logic [3:0] bankSelect,
    input wire logic extendedSet,
    input wire logic [11:0] indexBase,
    // Data memory
    input wire logic [7:0] memReadData,
    output logic [11:0] memAddr,
    output logic memRead,
    output logic memWrite,
    output logic [7:0] memWriteData,
    // Core state
    output logic [7:0] workReg,
    output logic negFlag,
    output logic zeroFlag,
    output logic [3:0] phase,
    output logic noOpCycle
);
    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    function automatic logic [11:0] dataAddress(input logic [15:0] iw,
        input logic [3:0] bankSel, input logic ext, input logic [11:0] base);
        logic [7:0] f;
        f = iw[7:0];
        if (iw[cmp_skip_pkg::ACCESS_BIT])
            dataAddress = {bankSel, f};                                        // [RULE4]
        else if (ext && f <= cmp_skip_pkg::INDEXED_LIMIT)
            dataAddress = 12'(base + {4'h0, f});                               // [RULE5]
        else if (f < cmp_skip_pkg::ACCESS_HIGH_BASE)
            dataAddress = {cmp_skip_pkg::ACCESS_LOW_BANK, f};                  // [RULE3]
        else
            dataAddress = {cmp_skip_pkg::ACCESS_HIGH_BANK, f};                 // [RULE3]
    endfunction : dataAddress

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    cmp_skip_pkg::phase_t phase_r, phase_nxt;
    logic [15:0] instr_r, instr_nxt;
    logic [11:0] addr_r, addr_nxt;
    logic [7:0] result_r, result_nxt;
    logic [7:0] work_r, work_nxt;
    logic neg_r, neg_nxt, zero_r, zero_nxt;
    logic [1:0] skip_r, skip_nxt;
    logic busy_r, busy_nxt;
    logic twoWord_r, twoWord_nxt;
    logic rd_r, rd_nxt, wr_r, wr_nxt;
    logic [7:0] wdata_r, wdata_nxt;
    logic isComp, isCmp, equal;
    logic [8:0] diff;

    assign isComp = busy_r && instr_r[15:10] == cmp_skip_pkg::COMPLEMENT_OPC;
    assign isCmp = busy_r && instr_r[15:9] == cmp_skip_pkg::COMPARE_EQ_OPC;
    // Unsigned subtraction; zero difference means equal
    assign diff = {1'b0, memReadData} - {1'b0, work_r};                       // [RULE6]
    assign equal = diff == 9'h000;

    // Next-state computation per phase
    always_comb
    begin
        phase_nxt = phase_r;
        instr_nxt = instr_r;
        addr_nxt = addr_r;
        result_nxt = result_r;
        work_nxt = work_r;
        neg_nxt = neg_r;
        zero_nxt = zero_r;
        skip_nxt = skip_r;
        busy_nxt = busy_r;
        twoWord_nxt = twoWord_r;
        rd_nxt = 1'b0;
        wr_nxt = 1'b0;
        wdata_nxt = wdata_r;
        case (phase_r)
            cmp_skip_pkg::PH_Q1:
            begin
                phase_nxt = cmp_skip_pkg::PH_Q2;
                // A pending skip turns this whole cycle into a no-operation
                if (skip_r != 2'h0)
                begin
                    busy_nxt = 1'b0;
                    skip_nxt = 2'(skip_r - 2'h1);                              // [RULE7] [RULE8]
                end
                else
                begin
                    busy_nxt = 1'b1;
                    instr_nxt = instrWord;                                    // [RULE10]
                    twoWord_nxt = nextIsTwoWord;
                    addr_nxt = dataAddress(instrWord, bankSelect, extendedSet, indexBase);
                end
            end
            cmp_skip_pkg::PH_Q2:
            begin
                phase_nxt = cmp_skip_pkg::PH_Q3;
                rd_nxt = isComp || isCmp;
            end
            cmp_skip_pkg::PH_Q3:
            begin
                phase_nxt = cmp_skip_pkg::PH_Q4;
                if (isComp)
                    result_nxt = ~memReadData;                                 // [RULE1]
                if (isCmp && equal)
                    skip_nxt = twoWord_r ? 2'h2 : 2'h1;                        // [RULE7] [RULE8]
            end
            cmp_skip_pkg::PH_Q4:
            begin
                phase_nxt = cmp_skip_pkg::PH_Q1;
                // Only complement writes; compare leaves W, flags, memory alone
                if (isComp)
                begin
                    neg_nxt = result_r[7];                                     // [RULE9]
                    zero_nxt = result_r == 8'h00;                              // [RULE9]
                    if (instr_r[cmp_skip_pkg::DEST_BIT])
                    begin
                        wr_nxt = 1'b1;                                         // [RULE2]
                        wdata_nxt = result_r;
                    end
                    else
                        work_nxt = result_r;                                   // [RULE2]
                end
            end
            default:
                phase_nxt = cmp_skip_pkg::PH_Q1;
        endcase
    end

    // Registers
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            phase_r <= cmp_skip_pkg::PH_Q1;
            instr_r <= 16'h0000;
            addr_r <= 12'h000;
            result_r <= 8'h00;
            work_r <= cmp_skip_pkg::WORK_RESET;
            neg_r <= 1'b0;
            zero_r <= 1'b0;
            skip_r <= cmp_skip_pkg::SKIP_RESET;
            busy_r <= 1'b0;
            twoWord_r <= 1'b0;
            rd_r <= 1'b0;
            wr_r <= 1'b0;
            wdata_r <= 8'h00;
        end
        else
        begin
            phase_r <= phase_nxt;
            instr_r <= instr_nxt;
            addr_r <= addr_nxt;
            result_r <= result_nxt;
            work_r <= work_nxt;
            neg_r <= neg_nxt;
            zero_r <= zero_nxt;
            skip_r <= skip_nxt;
            busy_r <= busy_nxt;
            twoWord_r <= twoWord_nxt;
            rd_r <= rd_nxt;
            wr_r <= wr_nxt;
            wdata_r <= wdata_nxt;
        end
    end

    // Outputs
    assign memAddr = addr_r;
    assign memRead = rd_r;
    assign memWrite = wr_r;
    assign memWriteData = wdata_r;
    assign workReg = work_r;
    assign negFlag = neg_r;
    assign zeroFlag = zero_r;
    assign phase = phase_r;
    assign noOpCycle = !busy_r;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    comp_invert_a: assert property (@(posedge clock) disable iff (!reset_n) // [RULE1]
        (phase_r == cmp_skip_pkg::PH_Q3 && isComp) |=> result_r == ~$past(memReadData))
        else $error("complement result not inverse");
    dest_file_a: assert property (@(posedge clock) disable iff (!reset_n) // [RULE2]
        (phase_r == cmp_skip_pkg::PH_Q4 && isComp && instr_r[cmp_skip_pkg::DEST_BIT])
        |=> memWrite && memWriteData == $past(result_r) && $stable(workReg))
        else $error("file destination not written");
    dest_work_a: assert property (@(posedge clock) disable iff (!reset_n) // [RULE2]
        (phase_r == cmp_skip_pkg::PH_Q4 && isComp && !instr_r[cmp_skip_pkg::DEST_BIT])
        |=> !memWrite && workReg == $past(result_r))
        else $error("working destination not written");
    bank_addr_a: assert property (@(posedge clock) disable iff (!reset_n) // [RULE4]
        (phase_r == cmp_skip_pkg::PH_Q1 && skip_r == 2'h0
         && instrWord[cmp_skip_pkg::ACCESS_BIT])
        |=> memAddr == {$past(bankSelect), $past(instrWord[7:0])})
        else $error("banked address wrong");
    access_addr_a: assert property (@(posedge clock) disable iff (!reset_n) // [RULE3]
        (phase_r == cmp_skip_pkg::PH_Q1 && skip_r == 2'h0
         && !instrWord[cmp_skip_pkg::ACCESS_BIT] && !extendedSet)
        |=> memAddr[7:0] == $past(instrWord[7:0]))
        else $error("access address wrong");
    indexed_addr_a: assert property (@(posedge clock) disable iff (!reset_n) // [RULE5]
        (phase_r == cmp_skip_pkg::PH_Q1 && skip_r == 2'h0
         && !instrWord[cmp_skip_pkg::ACCESS_BIT] && extendedSet
         && instrWord[7:0] <= cmp_skip_pkg::INDEXED_LIMIT)
        |=> memAddr == 12'($past(indexBase) + {4'h0, $past(instrWord[7:0])}))
        else $error("indexed address wrong");
    skip_one_a: assert property (@(posedge clock) disable iff (!reset_n) // [RULE7]
        (phase_r == cmp_skip_pkg::PH_Q3 && isCmp && equal && !twoWord_r)
        |=> ##2 noOpCycle [*4] ##1 !noOpCycle)
        else $error("single skip cycle wrong");
    skip_two_a: assert property (@(posedge clock) disable iff (!reset_n) // [RULE8]
        (phase_r == cmp_skip_pkg::PH_Q3 && isCmp && equal && twoWord_r)
        |=> ##2 noOpCycle [*8] ##1 !noOpCycle)
        else $error("double skip cycles wrong");
    cmp_quiet_a: assert property (@(posedge clock) disable iff (!reset_n) // [RULE9]
        isCmp |=> $stable(workReg) && $stable(negFlag) && $stable(zeroFlag) && !memWrite)
        else $error("compare changed state");
    no_skip_a: assert property (@(posedge clock) disable iff (!reset_n) // [RULE6]
        (phase_r == cmp_skip_pkg::PH_Q3 && isCmp && !equal) |=> skip_r == 2'h0)
        else $error("skip without equality");
    comp_flags_a: assert property (@(posedge clock) disable iff (!reset_n) // [RULE10]
        (phase_r == cmp_skip_pkg::PH_Q4 && isComp)
        |=> zeroFlag == ($past(result_r) == 8'h00) && negFlag == $past(result_r[7]))
        else $error("flags not updated in Q4");
endmodule : cmp_skip_exec
`default_nettype wire

// ### bench/data_mem_model.sv
// Purpose: Behavioural data memory on the far side of the execution block
// Assumes: Read data is combinational while memRead is high
// Notes: Outside reads the bus shows the inverse of the last read, so stale data never passes
`timescale 1ns/1ns
`default_nettype none
module data_mem_model
(
    // Clock
    input wire logic clock,
    // Data port
    input wire logic [11:0] memAddr,
    input wire logic memRead,
    input wire logic memWrite,
    input wire logic [7:0] memWriteData,
    output logic [7:0] memReadData
);
    logic [7:0] mem [0:4095];
    logic [7:0] lastOut_r = 8'h00;
    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    // Writes land on the edge that ends the write pulse
    always @(posedge clock)
    begin
        if (memWrite)
            mem[memAddr] <= memWriteData;
        if (memRead)
            lastOut_r <= mem[memAddr];
    end
    // Released bus, inverted rather than held
    assign memReadData = memRead ? mem[memAddr] : ~lastOut_r;
endmodule : data_mem_model
`default_nettype wire

// ### bench/tb_cmp_skip_exec.sv
// Purpose: Self-checking bench for the complement and compare-skip block
// Assumes: One instruction word per four phases, issued in Q1
// Notes: Skipped cycles are counted as phases with noOpCycle high
`timescale 1ns/1ns
`default_nettype none
`define CHECK(act, exp) \
    begin \
        comparisons++; \
        if ((act) !== (exp)) \
        begin \
            n_mismatch++; \
            $display("ERROR t=%0t got %0h expected %0h", $time, act, exp); \
        end \
    end
module tb_cmp_skip_exec;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic [15:0] instrWord = 16'h0000;
    logic nextIsTwoWord = 1'b0;
    logic [3:0] bankSelect = 4'h0;
    logic extendedSet = 1'b0;
    logic [11:0] indexBase = 12'h000;
    logic [7:0] memReadData, memWriteData, workReg;
    logic [11:0] memAddr;
    logic memRead, memWrite, negFlag, zeroFlag, noOpCycle;
    logic [3:0] phase;
    int n_mismatch = 0;
    int comparisons = 0;
    int skips;
    int reads;
    logic [11:0] readAddr;
    cmp_skip_exec u_cmp_skip_exec (.clock(clock), .reset_n(reset_n), .instrWord(instrWord),
        .nextIsTwoWord(nextIsTwoWord), .bankSelect(bankSelect), .extendedSet(extendedSet),
        .indexBase(indexBase), .memReadData(memReadData), .memAddr(memAddr),
        .memRead(memRead), .memWrite(memWrite), .memWriteData(memWriteData),
        .workReg(workReg), .negFlag(negFlag), .zeroFlag(zeroFlag), .phase(phase),
        .noOpCycle(noOpCycle));
    data_mem_model mem_model (.clock(clock), .memAddr(memAddr), .memRead(memRead),
        .memWrite(memWrite), .memWriteData(memWriteData), .memReadData(memReadData));
    // ------------------------------------------------------------------
    // Clock, verdict and watchdog
    // ------------------------------------------------------------------
    initial
    begin
        forever #25 clock = ~clock;
    end
    task automatic results();
        if (n_mismatch == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : results
    // Whole run needs well under 300 cycles
    initial
    begin
        #(1000 * 50);
        n_mismatch++;
        results();
    end
    // Issue one word at the Q1 edge, then count skipped phases over sixteen clocks
    task automatic run(input logic [15:0] word, input logic two);
        skips = 0;
        reads = 0;
        do
        begin
            @(posedge clock);
            #1;
        end
        while (phase !== cmp_skip_pkg::PH_Q4);
        @(posedge clock);
        instrWord <= word;
        nextIsTwoWord <= two;
        repeat (16)
        begin
            @(posedge clock);
            instrWord <= 16'h0000;
            nextIsTwoWord <= 1'b0;
            #1;
            if (noOpCycle === 1'b1)
                skips++;
            // Count data reads and keep the address of the last one
            if (memRead === 1'b1)
            begin
                reads++;
                readAddr = memAddr;
            end
        end
    endtask : run
    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial
    begin
        mem_model.mem[12'h313] = 8'h13;
        mem_model.mem[12'h013] = 8'h55;
        mem_model.mem[12'hF13] = 8'h77;
        mem_model.mem[12'hF70] = 8'hFF;
        mem_model.mem[12'h020] = 8'h0F;
        mem_model.mem[12'h25F] = 8'h3C;
        mem_model.mem[12'h05F] = 8'h99;
        mem_model.mem[12'hF60] = 8'h01;
        mem_model.mem[12'h240] = 8'hEC;
        mem_model.mem[12'h241] = 8'hED;
        mem_model.mem[12'h210] = 8'hEC;
        repeat (8) @(posedge clock);
        reset_n <= 1'b1;
        bankSelect <= 4'h3;
        // Banked complement into the working register
        run({cmp_skip_pkg::COMPLEMENT_OPC, 2'b01, 8'h13}, 1'b0);
        `CHECK(workReg, 8'hEC);
        `CHECK(negFlag, 1'b1);
        `CHECK(zeroFlag, 1'b0);
        `CHECK(mem_model.mem[12'h313], 8'h13);
        `CHECK(skips, 0);
        `CHECK(reads, 1);
        `CHECK(readAddr, 12'h313);
        // Access bank, upper half and lower half
        run({cmp_skip_pkg::COMPLEMENT_OPC, 2'b10, 8'h70}, 1'b0);
        `CHECK(mem_model.mem[12'hF70], 8'h00);
        `CHECK(readAddr, 12'hF70);
        `CHECK(zeroFlag, 1'b1);
        `CHECK(negFlag, 1'b0);
        `CHECK(workReg, 8'hEC);
        run({cmp_skip_pkg::COMPLEMENT_OPC, 2'b10, 8'h20}, 1'b0);
        `CHECK(mem_model.mem[12'h020], 8'hF0);
        // Indexed mode at the limit and just above it
        @(posedge clock);
        extendedSet <= 1'b1;
        indexBase <= 12'h200;
        run({cmp_skip_pkg::COMPLEMENT_OPC, 2'b10, 8'h5F}, 1'b0);
        `CHECK(mem_model.mem[12'h25F], 8'hC3);
        `CHECK(readAddr, 12'h25F);
        `CHECK(mem_model.mem[12'h05F], 8'h99);
        run({cmp_skip_pkg::COMPLEMENT_OPC, 2'b10, 8'h60}, 1'b0);
        `CHECK(mem_model.mem[12'hF60], 8'hFE);
        `CHECK(negFlag, 1'b1);
        // Compare equal, equal with two-word follower, unequal, indexed
        @(posedge clock);
        bankSelect <= 4'h2;
        run({cmp_skip_pkg::COMPARE_EQ_OPC, 1'b1, 8'h40}, 1'b0);
        `CHECK(skips, 4);
        run({cmp_skip_pkg::COMPARE_EQ_OPC, 1'b1, 8'h40}, 1'b1);
        `CHECK(skips, 8);
        run({cmp_skip_pkg::COMPARE_EQ_OPC, 1'b1, 8'h41}, 1'b1);
        `CHECK(skips, 0);
        run({cmp_skip_pkg::COMPARE_EQ_OPC, 1'b0, 8'h10}, 1'b0);
        `CHECK(skips, 4);
        `CHECK(readAddr, 12'h210);
        `CHECK(workReg, 8'hEC);
        `CHECK(negFlag, 1'b1);
        `CHECK(zeroFlag, 1'b0);
        `CHECK(mem_model.mem[12'h240], 8'hEC);
        results();
    end
endmodule : tb_cmp_skip_exec
`default_nettype wire
